// ==== sim/arith_right_shift_unit_monitor.sv ====
// Port-level concurrent checks for the arithmetic right-shift unit
module arsh_monitor
    import arsh_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Status
    input wire logic              busy
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Command write accepted at its completing edge
    sequence cmd_take;
        psel && penable && pready && pwrite && !pslverr && paddr == OFF_CMD;
    endsequence

    // Busy across exactly the two execution cycles
    sequence busy_two;
        busy ##1 busy ##1 !busy;
    endsequence

    a_multi_two: assert property (cmd_take ##0 (pwdata[1] && pwdata[5:3] <= PAIR_LAST) |=> busy_two)
        else $error("shift-add or multi shift not done in two cycles");
    a_single_two: assert property (cmd_take ##0 (pwdata[1:0] == 2'h1 && !pwdata[6]) |=> busy_two)
        else $error("single shift without move not done in two cycles");
    a_single_move: assert property (cmd_take ##0 (pwdata[1:0] == 2'h1 && pwdata[6] && pwdata[11:8] == 4'h4)
        |=> busy[*6] ##1 !busy)
        else $error("single shift with move has wrong length");
    a_bad_pair: assert property (cmd_take ##0 (pwdata[1] && pwdata[5:3] > PAIR_LAST) |=> !busy[*2])
        else $error("illegal source pair started an operation");
    a_busy_cause: assert property ($rose(busy) |-> $past(psel && penable && pready && pwrite && paddr == OFF_CMD))
        else $error("busy rose without a command write");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered in one cycle");
    a_busy_refuse: assert property (psel && penable && pwrite && !pready && busy |=> pready && pslverr)
        else $error("write while busy not refused");
endmodule // arsh_monitor

// ==== sim/tb_arith_right_shift_unit.sv ====
// Self-checking bench for the arithmetic right-shift unit
module tb_arith_right_shift_unit
    import arsh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic [31:0] rd;
    logic        er;
    int          err_count;
    int          compares;

    arith_right_shift_unit #(.ADDR_W(8)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

    // Free-running 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One APB transfer; idle edge first so no signal is driven twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            err_count++;
            end_sim();
        end
    endtask

    // Counts the cycles that busy stays high after a command write
    task automatic busy_len(output int n);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (busy === 1'b1 && n < 40);
        if (n >= 40)
        begin
            err_count++;
            end_sim();
        end
        n = n - 1;
    endtask

    task automatic set_acc(input logic [7:0] base, input logic [35:0] v);
        apb(1'b1, base, {28'h0, v[35:32]});
        apb(1'b1, base + 8'h04, {16'h0, v[31:16]});
        apb(1'b1, base + 8'h08, {16'h0, v[15:0]});
    endtask

    task automatic get_acc(input logic [7:0] base, output logic [35:0] v);
        apb(1'b0, base, 32'h0);
        v[35:32] = rd[3:0];
        apb(1'b0, base + 8'h04, 32'h0);
        v[31:16] = rd[15:0];
        apb(1'b0, base + 8'h08, 32'h0);
        v[15:0] = rd[15:0];
    endtask

    task automatic t_reset();
        apb(1'b0, OFF_MODE, 32'h0);
        check(36'(rd), 36'(MODE_RESET));
        apb(1'b0, OFF_FLAGS, 32'h0);
        check(36'(rd), 36'(FLAGS_RESET));
        apb(1'b1, OFF_MODE, 32'h000000A5);
        apb(1'b0, OFF_MODE, 32'h0);
        check(36'(rd), 36'h0A5);
        apb(1'b0, 8'h40, 32'h0);
        check({35'h0, er}, 36'h1);
        check(36'(rd), 36'h0);
    endtask

    task automatic t_single();
        logic [35:0] v;
        int          n;
        set_acc(OFF_B_TOP, 36'hA_A864_A865);
        apb(1'b1, OFF_FLAGS, 32'h00000002);
        apb(1'b1, OFF_CMD, 32'h00000005);
        busy_len(n);
        check(36'(n), 36'h2);
        get_acc(OFF_B_TOP, v);
        check(v, 36'hD_5432_5432);
        apb(1'b0, OFF_FLAGS, 32'h0);
        // Carry from old bit 0, overflow cleared, negative and extension from the result
        check(36'(rd), 36'h029);
    endtask

    task automatic t_add();
        logic [35:0] v;
        int          n;
        set_acc(OFF_A_TOP, 36'h0_0000_0099);
        apb(1'b1, OFF_X0, 32'h00000004);
        apb(1'b1, OFF_Y1, 32'h0000C003);
        apb(1'b1, OFF_FLAGS, 32'h000000F3);
        apb(1'b1, OFF_CMD, 32'h00000002);
        busy_len(n);
        check(36'(n), 36'h2);
        get_acc(OFF_A_TOP, v);
        check(v, 36'hF_FC00_3099);
        apb(1'b0, OFF_FLAGS, 32'h0);
        check(36'(rd), 36'h0FB);
    endtask

    task automatic t_multi();
        logic [15:0] s1 [6] = '{16'h8001, 16'h0003, 16'h8001, 16'h0003, 16'h9000, 16'h8421};
        logic [15:0] s2 [6] = '{16'hFFF4, 16'hFFF4, 16'h0003, 16'h0003, 16'h0003, 16'h8001};
        logic [15:0] r;
        logic [35:0] v;
        apb(1'b1, OFF_X0, 32'h0000FFF4);
        apb(1'b1, OFF_Y0, 32'h00000003);
        apb(1'b1, OFF_Y1, 32'h00008001);
        apb(1'b1, OFF_B_MID, 32'h00008421);
        for (int p = 0; p < 6; p++)
        begin
            set_acc(OFF_A_TOP, 36'h0_9000_FFFF);
            apb(1'b1, OFF_CMD, 32'(p * 8 + 3));
            r = $signed(s1[p]) >>> s2[p][3:0];
            get_acc(OFF_A_TOP, v);
            check(v, {{4{r[15]}}, r, 16'h0});
            apb(1'b0, OFF_FLAGS, 32'h0);
            check(36'(rd[3:2]), 36'({r[15], r == 16'h0}));
        end
        apb(1'b1, OFF_CMD, 32'h00000033);
        apb(1'b0, OFF_STATUS, 32'h0);
        check(36'(rd[1:0]), 36'h2);
    endtask

    task automatic t_move();
        logic [35:0] v;
        int          n;
        set_acc(OFF_A_TOP, 36'h1_4000_0000);
        set_acc(OFF_B_TOP, 36'h0_0000_0002);
        apb(1'b1, OFF_FLAGS, 32'h0);
        apb(1'b1, OFF_CMD, 32'h00000445);
        busy_len(n);
        check(36'(n), 36'h6);
        get_acc(OFF_B_TOP, v);
        check(v, 36'h1);
        apb(1'b0, OFF_FLAGS, 32'h0);
        check(36'(rd[7:6]), 36'h3);
        apb(1'b0, OFF_MOVE, 32'h0);
        check(36'(rd), 36'(LIMIT_POS));
        // Second shift moves from B itself; the flag write during it is refused
        apb(1'b1, OFF_CMD, 32'h000004C5);
        apb(1'b1, OFF_FLAGS, 32'h0);
        check({35'h0, er}, 36'h1);
        busy_len(n);
        apb(1'b0, OFF_MOVE, 32'h0);
        check(36'(rd), 36'h0);
        apb(1'b0, OFF_FLAGS, 32'h0);
        check(36'(rd), 36'h0D5);
    endtask

    // Reset, scenarios, verdict
    initial
    begin
        err_count = 0;
        compares  = 0;
        rst       = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_single();
        t_add();
        t_multi();
        t_move();
        end_sim();
    end
endmodule // tb_arith_right_shift_unit

bind arith_right_shift_unit arsh_monitor #(.ADDR_W(ADDR_W)) i_mon (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

// ==== verilog/arith_right_shift_unit.sv ====
// Arithmetic right-shift data path with APB register access
module arith_right_shift_unit
    import arsh_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Status
    output logic                   busy
);

    typedef struct packed {
        state_t      state;
        logic [3:0]  moveLeft;
        op_t         op;
        logic        destB;
        logic [2:0]  pair;
        logic        moveEn;
        logic        moveSrcB;
        logic [3:0]  moveCycles;
        logic        badPair;
        logic [7:0]  mode;
        logic [7:0]  flags;
        logic [15:0] x0;
        logic [15:0] y0;
        logic [15:0] y1;
        logic [15:0] moveWord;
        logic [35:0] accA;
        logic [35:0] accB;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        busy;
    } regs_t;

    localparam regs_t REGS_RESET = '{
        state:    ST_IDLE,
        op:       OP_NONE,
        mode:     MODE_RESET,
        flags:    FLAGS_RESET,
        default:  '0
    };

    regs_t s;
    regs_t next_s;

    // Address decode, used by the error check only; the read path compares addr8 directly
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = 8'(a);
        isMapped = (b[1:0] == 2'h0) && (b <= OFF_B_LOW);
    endfunction

    function automatic logic [31:0] pairSrc(input logic [2:0] p, input regs_t r);
        logic [31:0] v;
        v = '0;
        case (p)
            3'h0:    v = {r.y1, r.x0};
            3'h1:    v = {r.y0, r.x0};
            3'h2:    v = {r.y1, r.y0};
            3'h3:    v = {r.y0, r.y0};
            3'h4:    v = {r.accA[31:16], r.y0};
            3'h5:    v = {r.accB[31:16], r.y1};
            default: v = '0;
        endcase
        pairSrc = v;
    endfunction

    logic [35:0] destAcc;
    logic [35:0] moveAcc;
    logic [31:0] srcPair;
    logic [35:0] shiftResult;
    logic        shiftCarry;
    logic        fNeg;
    logic        fZero;
    logic        fExt;
    logic        fUnnorm;
    logic        mvExt;
    logic        wrTake;
    logic [7:0]  addr8;

    assign destAcc = s.destB ? s.accB : s.accA;
    assign moveAcc = s.moveSrcB ? s.accB : s.accA;
    assign srcPair = pairSrc(s.pair, s);
    assign addr8   = 8'(paddr);
    assign mvExt   = !((&moveAcc[35:31]) || !(|moveAcc[35:31]));
    assign wrTake  = psel && penable && s.pready && pwrite && !s.pslverr;

    // Shared shifter
    arsh_shift_core u_shift (
        .op     (s.op),
        .acc    (destAcc),
        .src1   (srcPair[31:16]),
        .src2   (srcPair[15:0]),
        .result (shiftResult),
        .carry  (shiftCarry)
    );

    // Flags of the new result
    arsh_flag_eval u_flags (
        .value    (shiftResult),
        .negative (fNeg),
        .zero     (fZero),
        .extInUse (fExt),
        .unnorm   (fUnnorm)
    );

    // Next-state logic: bus slave, command sequencer, result commit
    always_comb
    begin
        next_s        = s;
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;

        // One wait state; read data captured as pready rises
        if (psel && penable && !s.pready)
        begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !isMapped(paddr) || (pwrite && s.state != ST_IDLE);
            next_s.prdata  = '0;
            if (addr8 == OFF_MODE)
                next_s.prdata = {24'h0, s.mode};
            else if (addr8 == OFF_FLAGS)
                next_s.prdata = {24'h0, s.flags};
            else if (addr8 == OFF_CMD)
                next_s.prdata = {20'h0, s.moveCycles, s.moveSrcB, s.moveEn, s.pair, s.destB, s.op};
            else if (addr8 == OFF_STATUS)
                next_s.prdata = {30'h0, s.badPair, s.busy};
            else if (addr8 == OFF_X0)
                next_s.prdata = {16'h0, s.x0};
            else if (addr8 == OFF_Y0)
                next_s.prdata = {16'h0, s.y0};
            else if (addr8 == OFF_Y1)
                next_s.prdata = {16'h0, s.y1};
            else if (addr8 == OFF_MOVE)
                next_s.prdata = {16'h0, s.moveWord};
            else if (addr8 == OFF_A_TOP)
                next_s.prdata = {28'h0, s.accA[35:32]};
            else if (addr8 == OFF_A_MID)
                next_s.prdata = {16'h0, s.accA[31:16]};
            else if (addr8 == OFF_A_LOW)
                next_s.prdata = {16'h0, s.accA[15:0]};
            else if (addr8 == OFF_B_TOP)
                next_s.prdata = {28'h0, s.accB[35:32]};
            else if (addr8 == OFF_B_MID)
                next_s.prdata = {16'h0, s.accB[31:16]};
            else if (addr8 == OFF_B_LOW)
                next_s.prdata = {16'h0, s.accB[15:0]};
        end

        // Writes land only at the edge the master sees pready
        if (wrTake)
        begin
            if (addr8 == OFF_MODE)
                next_s.mode = pwdata[7:0];
            else if (addr8 == OFF_FLAGS)
                next_s.flags = pwdata[7:0];
            else if (addr8 == OFF_CMD)
            begin
                next_s.op         = op_t'(pwdata[CMD_OP_LSB +: 2]);
                next_s.destB      = pwdata[CMD_DEST_BIT];
                next_s.pair       = pwdata[CMD_PAIR_LSB +: 3];
                next_s.moveEn     = pwdata[CMD_MOVE_BIT];
                next_s.moveSrcB   = pwdata[CMD_MSRC_BIT];
                next_s.moveCycles = pwdata[CMD_MV_LSB +: 4];
                if (pwdata[CMD_OP_LSB +: 2] != OP_NONE)
                begin
                    if (pwdata[CMD_OP_LSB +: 2] != OP_ONE && pwdata[CMD_PAIR_LSB +: 3] > PAIR_LAST)
                        next_s.badPair = 1'b1;
                    else
                    begin
                        next_s.badPair = 1'b0;
                        next_s.state   = ST_FIRST;
                        next_s.busy    = 1'b1;
                    end
                end
            end
            else if (addr8 == OFF_X0)
                next_s.x0 = pwdata[15:0];
            else if (addr8 == OFF_Y0)
                next_s.y0 = pwdata[15:0];
            else if (addr8 == OFF_Y1)
                next_s.y1 = pwdata[15:0];
            else if (addr8 == OFF_A_TOP)
                next_s.accA[35:32] = pwdata[3:0];
            else if (addr8 == OFF_A_MID)
                next_s.accA[31:16] = pwdata[15:0];
            else if (addr8 == OFF_A_LOW)
                next_s.accA[15:0] = pwdata[15:0];
            else if (addr8 == OFF_B_TOP)
                next_s.accB[35:32] = pwdata[3:0];
            else if (addr8 == OFF_B_MID)
                next_s.accB[31:16] = pwdata[15:0];
            else if (addr8 == OFF_B_LOW)
                next_s.accB[15:0] = pwdata[15:0];
        end

        // Instruction sequencer
        case (s.state)
            ST_IDLE:
                next_s.moveLeft = '0;
            // extra cycles only for a single shift with a move
            // multi-bit forms go straight to the last cycle
            ST_FIRST:
            begin
                if (s.op == OP_ONE && s.moveEn && s.moveCycles != 4'h0)
                begin
                    next_s.moveLeft = s.moveCycles;
                    next_s.state    = ST_MOVE;
                end
                else
                    next_s.state = ST_LAST;
            end
            ST_MOVE:
            begin
                next_s.moveLeft = s.moveLeft - 4'h1;
                if (s.moveLeft == 4'h1)
                    next_s.state = ST_LAST;
            end
            ST_LAST:
            begin
                next_s.state = ST_IDLE;
                next_s.busy  = 1'b0;
                if (s.destB)
                    next_s.accB = shiftResult;
                else
                    next_s.accA = shiftResult;
                // negative and zero on every form
                next_s.flags[FLG_N] = fNeg;
                next_s.flags[FLG_Z] = fZero;
                if (s.op == OP_ONE)
                begin
                    next_s.flags[FLG_C] = shiftCarry;
                    next_s.flags[FLG_V] = 1'b0;
                    next_s.flags[FLG_E] = fExt;
                    next_s.flags[FLG_U] = fUnnorm;
                    if (s.moveEn)
                    begin
                        // Move reads the source before the shift, limited if it overflows a word
                        next_s.moveWord = mvExt ? (moveAcc[35] ? LIMIT_NEG : LIMIT_POS) : moveAcc[31:16];
                        next_s.flags[FLG_L] = s.flags[FLG_L] | mvExt;
                        next_s.flags[FLG_SZ] = s.flags[FLG_SZ] | (moveAcc[30] ^ moveAcc[29]);
                    end
                end
            end
            default:
                next_s.state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            s <= REGS_RESET;
        else
            s <= next_s;
    end

    // Outputs straight from flops
    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;
    assign busy    = s.busy;

endmodule // arith_right_shift_unit

// ==== verilog/arsh_flag_eval.sv ====
// Result flag evaluation for a 36-bit accumulator value
module arsh_flag_eval
(
    // Value under test
    input  wire logic [35:0] value,
    // Flags
    output logic             negative,
    output logic             zero,
    output logic             extInUse,
    output logic             unnorm
);

    assign negative = value[35];
    assign zero     = (value == 36'h0);
    assign extInUse = !((&value[35:31]) || !(|value[35:31]));
    // unnormalized when bits 31 and 30 agree
    assign unnorm   = (value[31] == value[30]);

endmodule // arsh_flag_eval

// ==== verilog/arsh_pkg.sv ====
// Constants and types shared by the arithmetic right-shift unit
package arsh_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFF_MODE   = 8'h00;
    localparam logic [7:0] OFF_FLAGS  = 8'h04;
    localparam logic [7:0] OFF_CMD    = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_X0     = 8'h10;
    localparam logic [7:0] OFF_Y0     = 8'h14;
    localparam logic [7:0] OFF_Y1     = 8'h18;
    localparam logic [7:0] OFF_MOVE   = 8'h1C;
    localparam logic [7:0] OFF_A_TOP  = 8'h20;
    localparam logic [7:0] OFF_A_MID  = 8'h24;
    localparam logic [7:0] OFF_A_LOW  = 8'h28;
    localparam logic [7:0] OFF_B_TOP  = 8'h2C;
    localparam logic [7:0] OFF_B_MID  = 8'h30;
    localparam logic [7:0] OFF_B_LOW  = 8'h34;

    // Command register fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_DEST_BIT = 2;
    localparam int CMD_PAIR_LSB = 3;
    localparam int CMD_MOVE_BIT = 6;
    localparam int CMD_MSRC_BIT = 7;
    localparam int CMD_MV_LSB   = 8;

    // Condition flag byte bit positions
    localparam int FLG_C  = 0;
    localparam int FLG_V  = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_N  = 3;
    localparam int FLG_U  = 4;
    localparam int FLG_E  = 5;
    localparam int FLG_L  = 6;
    localparam int FLG_SZ = 7;

    // Status register bits
    localparam int STS_BUSY    = 0;
    localparam int STS_BADPAIR = 1;

    // Reset values
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // Highest legal source pair code
    localparam logic [2:0] PAIR_LAST = 3'h5;

    // Move limiting values
    localparam logic [15:0] LIMIT_POS = 16'h7FFF;
    localparam logic [15:0] LIMIT_NEG = 16'h8000;

    typedef enum logic [1:0] {
        OP_NONE  = 2'h0,
        OP_ONE   = 2'h1,
        OP_ADD   = 2'h2,
        OP_MULTI = 2'h3
    } op_t;

    // Gray order along idle, first, move, last
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_FIRST = 2'h1,
        ST_MOVE  = 2'h3,
        ST_LAST  = 2'h2
    } state_t;

endpackage

// ==== verilog/arsh_shift_core.sv ====
// Combinational shifter for the three right-shift operations
module arsh_shift_core
    import arsh_pkg::*;
(
    // Operation and operands
    input  wire op_t         op,
    input  wire logic [35:0] acc,
    input  wire logic [15:0] src1,
    input  wire logic [15:0] src2,
    // Result
    output logic      [35:0] result,
    output logic             carry
);

    logic [3:0]  count;
    logic [35:0] wide;

    assign count = src2[3:0];

    // Source sits in the middle word so shifted-out bits land in the low word
    assign wide = $signed({{4{src1[15]}}, src1, 16'h0000}) >>> count;

    always_comb
    begin
        result = acc;
        carry  = 1'b0;
        case (op)
            OP_ONE:
            begin
                result = {acc[35], acc[35:1]};
                carry  = acc[0];
            end
            OP_ADD:
                result = acc + wide;
            OP_MULTI:
                result = {wide[35:16], 16'h0000};
            default:
                result = acc;
        endcase
    end

endmodule // arsh_shift_core
